// >>> hdl/pds_out_div.sv
// One output-bank divider with mode select and disabled-drive control.
// Assumes i_tick is a one-cycle pulse per edge of the bank's source clock.
`timescale 1ns/100ps
`default_nettype none
module pds_out_div (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_tick,
	input wire logic [pds_pkg::PDS_ODIV_CNT_W-1:0] i_count,
	input wire logic i_out_div_mode,
	input wire logic [1:0] i_disabled_drive_sel,
	output logic o_out,
	output logic o_out_oe
);
	import pds_pkg::*;

	logic [PDS_ODIV_CNT_W:0] cnt_reg;
	logic out_reg;
	logic oe_reg;
	logic all_ones;
	logic [PDS_ODIV_CNT_W:0] half;

	assign all_ones = (i_count == PDS_ODIV_CNT_ALL_ONES);
	assign half = {1'b0, i_count} + 8'h01;

	////////////////////////////////////////////////////////////////
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			cnt_reg <= '0;
			out_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else if (all_ones && !i_out_div_mode) begin
			// Disabled: stays powered, drives the selected low or high level, tristated for other selects, no clocks
			cnt_reg <= '0;
			out_reg <= (i_disabled_drive_sel == PDS_DRV_HIGH);
			oe_reg <= (i_disabled_drive_sel == PDS_DRV_LOW) || (i_disabled_drive_sel == PDS_DRV_HIGH);
		end else if (all_ones) begin
			out_reg <= i_tick;
			oe_reg <= 1'b1;
		end else if (!i_out_div_mode) begin
			oe_reg <= 1'b1;
			if (i_tick) begin
				out_reg <= ~out_reg;
			end
		end else begin
			oe_reg <= 1'b1;
			if (i_tick) begin
				// Toggle every count+2 ticks: period (count+2)*2
				if (cnt_reg >= half) begin
					cnt_reg <= '0;
					out_reg <= ~out_reg;
				end else begin
					cnt_reg <= cnt_reg + 8'h01;
				end
			end
		end
	end

	assign o_out = out_reg;
	assign o_out_oe = oe_reg;

endmodule
`default_nettype wire

// >>> hdl/pds_pkg.sv
// Package for the PLL divider and spread control block.
// Holds configuration byte indices, field positions, reset values and widths.
package pds_pkg;

	localparam int PDS_NUM_PLL = 4;
	localparam int PDS_NUM_BANK = 6;
	localparam int PDS_ADDR_W = 12;
	localparam int PDS_MEM_DEPTH = 256;

	// Per-PLL divider bytes: base + 4*pll; ref div, N low, {A, N high}
	localparam logic [7:0] PDS_IDX_PLL_BASE = 8'h10;
	localparam logic [7:0] PDS_IDX_PLL_STRIDE = 8'h04;
	localparam int PDS_REF_DIV_W = 7;
	localparam int PDS_FB_CNT_W = 12;
	localparam int PDS_FRAC_ADJ_W = 4;
	localparam int PDS_MULT_W = 14;
	localparam logic [7:0] PDS_PLL3_REF_MIN = 8'h03;

	// Output banks 1..6: {mode, count} then drive select byte
	localparam logic [7:0] PDS_IDX_BANK_BASE = 8'h20;
	localparam int PDS_ODIV_CNT_W = 7;
	localparam logic [6:0] PDS_ODIV_CNT_ALL_ONES = 7'h7f;
	localparam int PDS_MODE_BIT = 7;

	// Spread parameters of the first PLL, 0xac..0xbd
	localparam logic [7:0] PDS_IDX_SS_FIRST = 8'hac;
	localparam logic [7:0] PDS_IDX_SS_LAST = 8'hbd;
	localparam logic [7:0] PDS_IDX_SS_STEP = 8'hac;
	localparam logic [7:0] PDS_IDX_SS_CFG = 8'had;
	localparam logic [7:0] PDS_IDX_SS_DELTA = 8'hae;
	localparam int PDS_NSSC_POS = 4;
	localparam int PDS_LSB_RANDOMIZE_EN_POS = 6;
	localparam int PDS_X2_POS = 7;
	localparam int PDS_NUM_DELTA = 12;
	localparam logic [4:0] PDS_STEP_EXTRA = 5'h02;

	// Fourth PLL spread block, 0x4c..0x85
	localparam logic [7:0] PDS_IDX_P3_FIRST = 8'h4c;
	localparam logic [7:0] PDS_IDX_P3_LAST = 8'h85;
	localparam logic [7:0] PDS_IDX_P3_EN = 8'h4c;
	localparam logic [7:0] PDS_IDX_P3_REF = 8'h4d;
	localparam logic [7:0] PDS_IDX_P3_FB_LO = 8'h4e;
	localparam logic [7:0] PDS_IDX_P3_FB_HI = 8'h4f;
	localparam logic [7:0] PDS_IDX_P3_PUMP = 8'h50;
	localparam logic [7:0] PDS_IDX_P3_ZERO = 8'h51;

	// Read-only status words
	localparam logic [7:0] PDS_IDX_STAT_MULT = 8'hc8;
	localparam logic [7:0] PDS_IDX_STAT_SS = 8'hcc;
	localparam logic [7:0] PDS_IDX_STAT_PWR = 8'hcd;

	localparam logic [7:0] PDS_MEM_RST = 8'h00;
	localparam logic [15:0] PDS_LFSR_SEED = 16'hace1;
	localparam int PDS_FRAC_W = 11;

	// Disabled-drive encodings
	localparam logic [1:0] PDS_DRV_LOW = 2'h0;
	localparam logic [1:0] PDS_DRV_HIGH = 2'h1;

endpackage

// >>> hdl/pds_top.sv
// Divider and spread control for a four-PLL clock generator, APB register access.
// Assumes i_pfd_tick and i_bank_tick are one-cycle pulses made on i_mclk.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module pds_top (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [pds_pkg::PDS_ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_pfd_tick,
	input wire logic i_undivided_tick,
	input wire logic [pds_pkg::PDS_NUM_BANK-1:0] i_bank_tick,
	output logic o_undivided_output,
	output logic [pds_pkg::PDS_NUM_BANK-1:0] o_bank_out,
	output logic [pds_pkg::PDS_NUM_BANK-1:0] o_bank_out_oe,
	output logic [pds_pkg::PDS_NUM_PLL*pds_pkg::PDS_REF_DIV_W-1:0] o_ref_div,
	output logic [pds_pkg::PDS_NUM_PLL*pds_pkg::PDS_MULT_W-1:0] o_total_mult,
	output logic [2:0] o_pll_pwrdn,
	output logic o_pll3_ref_div_bad,
	output logic o_ss_active,
	output logic [pds_pkg::PDS_FRAC_W-1:0] o_ss_frac,
	output logic o_fourth_pll_spread_en,
	output logic [7:0] o_fourth_pll_spread_ref_div,
	output logic [15:0] o_fourth_pll_spread_fb_count,
	output logic [4:0] o_fourth_pll_pump_current,
	output logic [3:0] o_fourth_pll_zero_resistor
);
	import pds_pkg::*;

	////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [7:0] pll_idx(input int unsigned pll, input logic [7:0] off);
		pll_idx = PDS_IDX_PLL_BASE + 8'(pll * 4) + off;
	endfunction

	function automatic logic [PDS_MULT_W-1:0] mult_calc(input logic [11:0] n, input logic [3:0] a,
			input logic frac_pll);
		logic [PDS_MULT_W-1:0] twice;
		twice = {1'b0, n, 1'b0};
		if (!frac_pll) begin
			mult_calc = {2'b00, n};
		end else if (a != 4'h0) begin
			mult_calc = twice + {10'h000, a} + 14'h0001;
		end else begin
			mult_calc = twice;
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// Configuration memory and APB slave

	logic [7:0] mem [PDS_MEM_DEPTH];
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [7:0] idx;
	logic hi_bits_set;
	logic is_stat;
	logic access;
	logic [31:0] rd_value;
	logic [PDS_NUM_PLL*PDS_MULT_W-1:0] mult_all;
	logic [PDS_FRAC_W-1:0] frac_reg;
	logic ss_en;

	assign idx = i_paddr[9:2];
	assign hi_bits_set = (i_paddr[PDS_ADDR_W-1:10] != 2'h0) || (i_paddr[1:0] != 2'h0);
	assign is_stat = (idx >= PDS_IDX_STAT_MULT) && (idx <= PDS_IDX_STAT_PWR);
	assign access = i_psel && i_penable;

	always_comb begin
		rd_value = {24'h000000, mem[idx]};
		if (idx == PDS_IDX_STAT_SS) begin
			rd_value = {20'h00000, ss_en, frac_reg};
		end else if (idx == PDS_IDX_STAT_PWR) begin
			rd_value = {28'h0000000, o_pll3_ref_div_bad, o_pll_pwrdn};
		end else if (is_stat) begin
			rd_value = {18'h00000, mult_all[(idx - PDS_IDX_STAT_MULT) * PDS_MULT_W +: PDS_MULT_W]};
		end
	end

	// One wait state: answer data is captured on the same edge that pready rises
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end else if (access && !pready_reg) begin
			pready_reg <= 1'b1;
			pslverr_reg <= hi_bits_set || (i_pwrite && is_stat);
			prdata_reg <= (hi_bits_set || i_pwrite) ? 32'h00000000 : rd_value;
		end else begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			for (int i = 0; i < PDS_MEM_DEPTH; i++) begin
				mem[i] <= PDS_MEM_RST;
			end
		end else if (access && pready_reg && i_pwrite && !hi_bits_set && !is_stat) begin
			mem[idx] <= i_pwdata[7:0];
		end
	end

	assign o_prdata = prdata_reg;
	assign o_pready = pready_reg;
	assign o_pslverr = pslverr_reg;

	////////////////////////////////////////////////////////////////
	// Reference and feedback dividers

	logic [PDS_NUM_PLL*PDS_REF_DIV_W-1:0] ref_reg;
	logic [PDS_NUM_PLL*PDS_MULT_W-1:0] mult_reg;
	logic [2:0] pwrdn_reg;
	logic p3_bad_reg;

	always_comb begin
		for (int p = 0; p < PDS_NUM_PLL; p++) begin
			mult_all[p*PDS_MULT_W +: PDS_MULT_W] = mult_calc({mem[pll_idx(p, 8'h02)][3:0],
				mem[pll_idx(p, 8'h01)]}, mem[pll_idx(p, 8'h02)][7:4], p == 0);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			ref_reg <= '0;
			mult_reg <= '0;
			pwrdn_reg <= 3'h7;
			p3_bad_reg <= 1'b1;
		end else begin
			mult_reg <= mult_all;
			for (int p = 0; p < PDS_NUM_PLL; p++) begin
				ref_reg[p*PDS_REF_DIV_W +: PDS_REF_DIV_W] <= mem[pll_idx(p, 8'h00)][6:0];
			end
			for (int p = 0; p < 3; p++) begin
				pwrdn_reg[p] <= (mem[pll_idx(p, 8'h00)][6:0] == 7'h00);
			end
			p3_bad_reg <= ({1'b0, mem[pll_idx(3, 8'h00)][6:0]} < PDS_PLL3_REF_MIN);
		end
	end

	assign o_ref_div = ref_reg;
	assign o_total_mult = mult_reg;
	assign o_pll_pwrdn = pwrdn_reg;
	assign o_pll3_ref_div_bad = p3_bad_reg;

	////////////////////////////////////////////////////////////////
	// Output banks

	logic undiv_reg;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			undiv_reg <= 1'b0;
		end else begin
			undiv_reg <= i_undivided_tick;
		end
	end

	assign o_undivided_output = undiv_reg;

	for (genvar b = 0; b < PDS_NUM_BANK; b++) begin : g_bank
		pds_out_div u_div (
			.i_mclk(i_mclk),
			.i_sys_rst(i_sys_rst),
			.i_tick(i_bank_tick[b]),
			.i_count(mem[PDS_IDX_BANK_BASE + 8'(2 * b)][6:0]),
			.i_out_div_mode(mem[PDS_IDX_BANK_BASE + 8'(2 * b)][PDS_MODE_BIT]),
			.i_disabled_drive_sel(mem[PDS_IDX_BANK_BASE + 8'(2 * b + 1)][1:0]),
			.o_out(o_bank_out[b]),
			.o_out_oe(o_bank_out_oe[b])
		);
	end

	////////////////////////////////////////////////////////////////
	// Spread modulator of the first PLL

	logic [3:0] step_period;
	logic [2:0] samp_count;
	logic [5:0] offset;
	logic lsb_randomize_en;
	logic amplitude_double;
	logic [3:0] quad_len;
	logic [4:0] step_cnt_reg;
	logic [3:0] pos_reg;
	logic [1:0] quad_reg;
	logic [7:0] mag_reg;
	logic [15:0] lfsr_reg;
	logic [3:0] sel_k;
	logic [3:0] delta;
	logic [8:0] amp;
	logic [PDS_FRAC_W-1:0] amp_w;
	logic [PDS_FRAC_W-1:0] frac_next;

	function automatic logic [3:0] delta_samples(input logic [3:0] k);
		logic [7:0] b;
		b = mem[PDS_IDX_SS_DELTA + {5'h00, k[3:1]}];
		delta_samples = k[0] ? b[7:4] : b[3:0];
	endfunction

	assign step_period = mem[PDS_IDX_SS_STEP][3:0];
	assign samp_count = mem[PDS_IDX_SS_STEP][PDS_NSSC_POS +: 3];
	assign offset = mem[PDS_IDX_SS_CFG][5:0];
	assign lsb_randomize_en = mem[PDS_IDX_SS_CFG][PDS_LSB_RANDOMIZE_EN_POS];
	assign amplitude_double = mem[PDS_IDX_SS_CFG][PDS_X2_POS];
	assign ss_en = (step_period != 4'h0);
	assign quad_len = {samp_count, 1'b0};
	// Falling quadrants walk the deltas in mirror order
	assign sel_k = quad_reg[0] ? (quad_len - 4'h1 - pos_reg) : pos_reg;
	assign delta = delta_samples(sel_k);

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || !ss_en) begin
			step_cnt_reg <= '0;
			pos_reg <= '0;
			quad_reg <= '0;
			mag_reg <= '0;
		end else if (i_pfd_tick) begin
			if (step_cnt_reg == {1'b0, step_period} + PDS_STEP_EXTRA - 5'h01) begin
				step_cnt_reg <= '0;
				mag_reg <= quad_reg[0] ? mag_reg - {4'h0, delta} : mag_reg + {4'h0, delta};
				if (pos_reg >= quad_len - 4'h1) begin
					pos_reg <= '0;
					quad_reg <= quad_reg + 2'h1;
				end else begin
					pos_reg <= pos_reg + 4'h1;
				end
			end else begin
				step_cnt_reg <= step_cnt_reg + 5'h01;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			lfsr_reg <= PDS_LFSR_SEED;
		end else if (i_pfd_tick) begin
			lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
		end
	end

	always_comb begin
		amp = amplitude_double ? {mag_reg, 1'b0} : {1'b0, mag_reg};
		amp[0] = amp[0] ^ (lsb_randomize_en & lfsr_reg[0]);
		amp_w = {2'b00, amp};
		// Second half of the cycle goes below the start point
		frac_next = {5'h00, offset} + (quad_reg[1] ? (~amp_w + 11'h001) : amp_w);
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || !ss_en) begin
			frac_reg <= '0;
		end else begin
			frac_reg <= frac_next;
		end
	end

	assign o_ss_active = ss_en;
	assign o_ss_frac = frac_reg;

	////////////////////////////////////////////////////////////////
	// Fourth PLL spread fields

	logic p3_en_reg;
	logic [7:0] p3_ref_reg;
	logic [15:0] p3_fb_reg;
	logic [4:0] p3_pump_reg;
	logic [3:0] p3_zero_reg;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			p3_en_reg <= 1'b0;
			p3_ref_reg <= '0;
			p3_fb_reg <= '0;
			p3_pump_reg <= '0;
			p3_zero_reg <= '0;
		end else begin
			p3_en_reg <= mem[PDS_IDX_P3_EN][0];
			p3_ref_reg <= mem[PDS_IDX_P3_REF];
			p3_fb_reg <= {mem[PDS_IDX_P3_FB_HI], mem[PDS_IDX_P3_FB_LO]};
			p3_pump_reg <= mem[PDS_IDX_P3_PUMP][4:0];
			p3_zero_reg <= mem[PDS_IDX_P3_ZERO][3:0];
		end
	end

	assign o_fourth_pll_spread_en = p3_en_reg;
	assign o_fourth_pll_spread_ref_div = p3_ref_reg;
	assign o_fourth_pll_spread_fb_count = p3_fb_reg;
	assign o_fourth_pll_pump_current = p3_pump_reg;
	assign o_fourth_pll_zero_resistor = p3_zero_reg;

endmodule
`default_nettype wire

// >>> test/pds_top_checker.sv
// Concurrent checks on the ports of pds_top.
// Assumes it is bound to pds_top and clocked by i_mclk.
`timescale 1ns/100ps
`default_nettype none
module pds_top_checker (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_undivided_tick,
	input wire logic o_undivided_output,
	input wire logic [pds_pkg::PDS_NUM_BANK-1:0] o_bank_out_oe,
	input wire logic [pds_pkg::PDS_NUM_PLL*pds_pkg::PDS_REF_DIV_W-1:0] o_ref_div,
	input wire logic [pds_pkg::PDS_NUM_PLL*pds_pkg::PDS_MULT_W-1:0] o_total_mult,
	input wire logic [2:0] o_pll_pwrdn,
	input wire logic o_ss_active
);
	import pds_pkg::*;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	////////////////////////////////////////////////////////////////
	a_pready_wait: assert property ($rose(i_penable) && i_psel |=> o_pready)
		else $error("pready not after one wait state");
	a_pready_pulse: assert property (o_pready |=> !o_pready)
		else $error("pready longer than one cycle");
	a_err_ready: assert property (o_pslverr |-> o_pready)
		else $error("pslverr without pready");
	a_undiv_delay: assert property ($rose(i_undivided_tick) |=> $rose(o_undivided_output))
		else $error("undivided output not one cycle behind");
	a_pwrdn_reset: assert property ($fell(i_sys_rst) |-> o_pll_pwrdn == 3'h7)
		else $error("pll not powered down after reset");
	a_oe_after_reset: assert property ($fell(i_sys_rst) |=> &o_bank_out_oe)
		else $error("bank divider not enabled after reset");
	a_ss_by_write: assert property ($changed(o_ss_active) |-> $past(o_pready && i_pwrite))
		else $error("spread enable changed without write");
	a_refdiv_write: assert property ($changed(o_ref_div) |->
		$past(o_pready && i_pwrite) || $past(o_pready && i_pwrite, 2))
		else $error("ref divider changed without write");
	a_mult_write: assert property ($changed(o_total_mult) |->
		$past(o_pready && i_pwrite) || $past(o_pready && i_pwrite, 2))
		else $error("multiplier changed without write");
endmodule
bind pds_top pds_top_checker chk_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.i_undivided_tick(i_undivided_tick), .o_undivided_output(o_undivided_output),
	.o_bank_out_oe(o_bank_out_oe), .o_ref_div(o_ref_div), .o_total_mult(o_total_mult),
	.o_pll_pwrdn(o_pll_pwrdn), .o_ss_active(o_ss_active));
`default_nettype wire

// >>> test/pds_top_tb.sv
// Self-checking bench for pds_top over APB.
// Assumes pds_pkg and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module pds_top_tb;
	import pds_pkg::*;
	logic mclk, sys_rst, psel, penable, pwrite, pfd_tick, und_tick, pready, pslverr, und_out, ss_act, err, p3_en, p3_bad;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0] bank_tick, bank_out, bank_oe;
	logic [27:0] ref_div;
	logic [55:0] mult;
	logic [2:0] pwrdn;
	logic [10:0] frac;
	logic [15:0] p3_fb;
	logic [7:0] p3_ref;
	logic [4:0] p3_pump;
	logic [3:0] p3_zero;
	int n_mismatch, check_count;
	pds_top dut_u (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_pfd_tick(pfd_tick), .i_undivided_tick(und_tick), .i_bank_tick(bank_tick),
		.o_undivided_output(und_out), .o_bank_out(bank_out), .o_bank_out_oe(bank_oe), .o_ref_div(ref_div),
		.o_total_mult(mult), .o_pll_pwrdn(pwrdn), .o_pll3_ref_div_bad(p3_bad), .o_ss_active(ss_act),
		.o_ss_frac(frac), .o_fourth_pll_spread_en(p3_en), .o_fourth_pll_spread_ref_div(p3_ref),
		.o_fourth_pll_spread_fb_count(p3_fb), .o_fourth_pll_pump_current(p3_pump),
		.o_fourth_pll_zero_resistor(p3_zero));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h want %h", $time, msg, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) n_mismatch++;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, {2'h0, idx, 2'h0}, {24'h0, d});
	endtask
	task automatic settle();
		repeat (3) @(posedge mclk);
	endtask
	task automatic ticks(input int n, output int t);
		logic prev;
		t = 0;
		prev = bank_out[0];
		repeat (n) begin
			bank_tick <= 6'h01;
			@(posedge mclk);
			bank_tick <= 6'h00;
			repeat (2) @(posedge mclk);
			if (bank_out[0] !== prev) t++;
			prev = bank_out[0];
		end
	endtask
	task automatic sweep(output int lo, output int hi, output int rmin, output int rmax);
		int run;
		logic [10:0] prev;
		lo = 1000;
		hi = -1000;
		rmin = 1000;
		rmax = 0;
		run = -1000;
		repeat (20) @(posedge mclk);
		prev = frac;
		repeat (140) begin
			@(posedge mclk);
			if ($signed(frac) < lo) lo = $signed(frac);
			if ($signed(frac) > hi) hi = $signed(frac);
			run++;
			if (frac !== prev) begin
				if (run > 0 && run < rmin) rmin = run;
				if (run > rmax) rmax = run;
				run = 0;
			end
			prev = frac;
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		apb(1'b0, 12'h040, 32'h0);
		check(rd, 32'h0, "ref div read");
		check(pwrdn, 32'h7, "pwrdn");
		check(bank_oe, 32'h3f, "bank oe");
		$display("t_reset done");
	endtask
	task automatic t_mult();
		wr(8'h10, 8'h01);
		wr(8'h11, 8'h16);
		wr(8'h12, 8'h30);
		settle();
		check(mult[13:0], 32'h30, "2N+A+1");
		check(pwrdn[0], 32'h0, "pll0 up");
		wr(8'h12, 8'h00);
		settle();
		check(mult[13:0], 32'h2c, "2N");
		wr(8'h14, 8'h7f);
		wr(8'h15, 8'hff);
		wr(8'h16, 8'hff);
		wr(8'h1c, 8'h02);
		settle();
		check(ref_div[13:7], 32'h7f, "ref div");
		check(mult[27:14], 32'hfff, "M=N");
		check(p3_bad, 32'h1, "pll3 ref 2");
		wr(8'h1c, 8'h03);
		apb(1'b0, 12'h320, 32'h0);
		check(rd, 32'h2c, "mult status");
		check(p3_bad, 32'h0, "pll3 ref 3");
		apb(1'b0, 12'h334, 32'h0);
		check(rd, 32'h4, "power status");
		$display("t_mult done");
	endtask
	task automatic t_div();
		int t;
		wr(8'h20, 8'h7f);
		for (int s = 0; s < 4; s++) begin
			wr(8'h21, s[7:0]);
			settle();
			check(bank_oe[0], s < 2, "disabled oe");
			if (s < 2) check(bank_out[0], s == 1, "disabled level");
		end
		wr(8'h20, 8'hff);
		bank_tick <= 6'h01;
		und_tick <= 1'b1;
		repeat (2) @(posedge mclk);
		check(bank_out[0], 32'h1, "pass high");
		check(und_out, 32'h1, "undivided");
		bank_tick <= 6'h00;
		und_tick <= 1'b0;
		repeat (2) @(posedge mclk);
		check(bank_out[0], 32'h0, "pass low");
		wr(8'h20, 8'h00);
		ticks(6, t);
		ticks(6, t);
		check(t, 32'h6, "div 2");
		wr(8'h20, 8'h81);
		ticks(9, t);
		ticks(9, t);
		check(t, 32'h3, "div 6");
		$display("t_div done");
	endtask
	task automatic t_spread();
		int lo, hi, rmin, rmax, odd;
		check(ss_act, 32'h0, "spread off");
		wr(8'h12, 8'h30);
		wr(8'had, 8'h04);
		wr(8'hae, 8'h23);
		wr(8'hac, 8'h15);
		settle();
		check(ss_act, 32'h1, "spread on");
		sweep(lo, hi, rmin, rmax);
		check(hi, 32'h9, "peak");
		check(lo, 32'hffffffff, "trough");
		check(rmin, 32'h7, "step min");
		check(rmax, 32'h7, "step max");
		wr(8'had, 8'h84);
		sweep(lo, hi, rmin, rmax);
		check(hi, 32'he, "x2 peak");
		check(lo, 32'hfffffffa, "x2 trough");
		apb(1'b0, 12'h2b4, 32'h0);
		check(rd, 32'h84, "readback");
		// Even offset and doubled amplitude: only dithering can make the output odd
		wr(8'had, 8'hc4);
		odd = 0;
		repeat (64) begin
			@(posedge mclk);
			if (frac[0] === 1'b1) odd++;
		end
		check(odd > 0, 32'h1, "dither lsb");
		wr(8'hac, 8'h10);
		settle();
		check(ss_act, 32'h0, "spread off");
		$display("t_spread done");
	endtask
	task automatic t_fourth();
		apb(1'b1, 12'h133, 32'h1);
		check(err, 32'h1, "misaligned");
		apb(1'b1, 12'h320, 32'h55);
		check(err, 32'h1, "status write");
		apb(1'b0, 12'hc40, 32'h0);
		check(err, 32'h1, "unmapped");
		check(p3_en, 32'h0, "no write");
		wr(8'h4c, 8'h01);
		wr(8'h4d, 8'h5a);
		wr(8'h4e, 8'h34);
		wr(8'h4f, 8'h12);
		wr(8'h50, 8'h13);
		wr(8'h51, 8'h09);
		settle();
		check(p3_en, 32'h1, "p3 enable");
		check(p3_ref, 32'h5a, "p3 ref");
		check(p3_fb, 32'h1234, "p3 fb");
		check(p3_pump, 32'h13, "p3 pump");
		check(p3_zero, 32'h9, "p3 zero");
		$display("t_fourth done");
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		#200000;
		n_mismatch++;
		conclude();
	end
	initial begin
		{sys_rst, psel, penable, pwrite, pfd_tick, und_tick} = 6'h20;
		paddr = 12'h0;
		pwdata = 32'h0;
		bank_tick = 6'h0;
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		pfd_tick <= 1'b1;
		t_reset();
		t_mult();
		t_div();
		t_spread();
		t_fourth();
		conclude();
	end
endmodule
`default_nettype wire
